// [core/smms_consts.svh]
// Purpose: constants of the management mode select front end
// Assumes: 40 MHz system clock
// Notes: definitions only
`ifndef SMMS_CONSTS_SVH
`define SMMS_CONSTS_SVH
`define SMMS_CLK_NS 25
`define SMMS_MDC_HALF_NS 200
`define SMMS_MDC_HALF_CYC ((`SMMS_MDC_HALF_NS + `SMMS_CLK_NS - 1) / `SMMS_CLK_NS)
`define SMMS_PRE_BITS 6'h20
`define SMMS_FRAME_LAST 5'h1F
`define SMMS_HDR_LAST 5'h0D
`define SMMS_TA_FIRST 5'h0E
`define SMMS_TA_LAST 5'h0F
`define SMMS_MM_LAST 7'h3F
`define SMMS_MM_TA 7'h2E
`define SMMS_MM_DATA 7'h30
`define SMMS_ROLE_MAC 1'h0
`define SMMS_MG_UNMAN 2'h0
`define SMMS_MG_EXT 2'h1
`define SMMS_MG_I2C 2'h2
`define SMMS_MG_SPI 2'h3
`define SMMS_OP_WR 2'h1
`define SMMS_OP_RD 2'h2
`define SMMS_STEP_FIX 2'h0
`define SMMS_STEP_INC 2'h1
`define SMMS_STEP_DEC 2'h2
`define SMMS_TGT_PHY 2'h0
`define SMMS_TGT_EXT 2'h1
`define SMMS_TGT_VPHY 2'h2
`define SMMS_STRAP_WAIT 2'h2
`define SMMS_LD_BASE_WORDS 16'h0010
`define SMMS_PREAMBLE 32'hFFFFFFFF
`define SMMS_SYNC_IDLE 10'h380
`define SMMS_FRM_MIN 11'h3F1
`define SMMS_FRM_MAX 11'h3F8
`endif

// [core/smms_pkg.sv]
// Purpose: types of the management mode select front end
// Assumes: nothing
// Notes: state enums only
package smms_pkg;
    typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_WAIT} smms_ld_e;
    typedef enum logic [1:0] {MM_IDLE, MM_FRAME, MM_INT} smms_mm_e;
endpackage

// [core/smms_top.sv]
// Purpose: strap-driven mode select, management slaves and master, eeprom loader
// Assumes: all pins and the mdc link clock are sampled by mclk
// Notes: i2c and spi frame engines sit outside; this block decodes their control
`include "smms_consts.svh"
module smms_top (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // straps
    input wire logic macStrap,
    input wire logic [1:0] mngtStrap,
    input wire logic eepTypeStrap,
    input wire logic [1:0] eepSizeStrap,
    // mode results
    output logic macMode,
    output logic [1:0] mgmtMode,
    output logic eepI2cSel,
    output logic [1:0] eepSize,
    output logic spiEnable,
    output logic i2cEnable,
    output logic mdioMasterEn,
    // mdio pins
    input wire logic mdcIn,
    output logic mdcOut,
    output logic mdcOe,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    // mdio slave register access
    output logic slvRdReq,
    output logic slvWrReq,
    output logic [1:0] slvTgt,
    output logic [4:0] slvPhyAddr,
    output logic [4:0] slvRegAddr,
    output logic [15:0] slvWrData,
    input wire logic [15:0] slvRdData,
    // phy management engine commands
    input wire logic pmStart,
    input wire logic pmWrite,
    input wire logic pmExt,
    input wire logic [4:0] pmPhyAddr,
    input wire logic [4:0] pmRegAddr,
    input wire logic [15:0] pmWrData,
    output logic pmBusy,
    output logic pmDone,
    output logic pmErr,
    output logic [15:0] pmRdData,
    output logic pmIntReq,
    input wire logic pmIntAck,
    input wire logic [15:0] pmIntRdData,
    // spi burst addressing
    input wire logic spiBurstStart,
    input wire logic [15:0] spiStartAddr,
    input wire logic [1:0] spiStep,
    input wire logic spiWordDone,
    output logic [15:0] spiRegAddr,
    // i2c pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic i2cStart,
    output logic i2cStop,
    output logic i2cByteValid,
    output logic [7:0] i2cByte,
    // loader triggers and config writes
    input wire logic digitalRst,
    input wire logic reloadCmd,
    output logic loadBusy,
    output logic loadDone,
    output logic cfgWr,
    output logic [15:0] cfgAddr,
    output logic [7:0] cfgData,
    // eeprom controller port
    output logic eepReq,
    output logic eepWrite,
    output logic [15:0] eepAddr,
    output logic [7:0] eepWrData,
    input wire logic eepAck,
    input wire logic [7:0] eepRdData,
    // cpu eeprom access
    input wire logic cpuEepReq,
    input wire logic cpuEepWrite,
    input wire logic [15:0] cpuEepAddr,
    input wire logic [7:0] cpuEepWrData,
    output logic cpuEepGrant,
    output logic cpuEepAck
);
    ////////////////////////////////////////////////////////////////////////////
    // synchronisers and straps
    logic [9:0] syncA, syncB;
    logic mdcD, sclD, sdaD, strapDone;
    logic [1:0] strapCnt;
    wire logic [9:0] asyncIn = {sdaIn, sclIn, mdioIn, mdcIn, mngtStrap, eepSizeStrap,
        eepTypeStrap, macStrap};
    wire logic mdcS = syncB[6];
    wire logic mdioS = syncB[7];
    wire logic sclS = syncB[8];
    wire logic sdaS = syncB[9];
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            syncA <= `SMMS_SYNC_IDLE;
            syncB <= `SMMS_SYNC_IDLE;
            {mdcD, sclD, sdaD} <= 3'h3;
        end else begin
            syncA <= asyncIn;
            syncB <= syncA;
            {mdcD, sclD, sdaD} <= {mdcS, sclS, sdaS};
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            strapCnt <= 2'h0;
            strapDone <= 1'b0;
            macMode <= 1'b0;
            mgmtMode <= 2'h0;
            eepI2cSel <= 1'b0;
            eepSize <= 2'h0;
        end else if (!strapDone) begin
            strapCnt <= strapCnt + 2'h1;
            if (strapCnt == `SMMS_STRAP_WAIT) begin
                strapDone <= 1'b1;
                macMode <= (syncB[0] == `SMMS_ROLE_MAC);
                eepI2cSel <= syncB[1];
                eepSize <= syncB[3:2];
                mgmtMode <= syncB[5:4];
            end
        end
    end
    wire logic extMode = (mgmtMode == `SMMS_MG_EXT);
    wire logic managed = (mgmtMode != `SMMS_MG_UNMAN);
    assign spiEnable = strapDone && (mgmtMode == `SMMS_MG_SPI);
    assign i2cEnable = strapDone && (mgmtMode == `SMMS_MG_I2C);
    assign mdioMasterEn = strapDone && macMode && mgmtMode[1];
    ////////////////////////////////////////////////////////////////////////////
    // mdio slave
    logic [5:0] preCnt;
    logic inFrame, slvDrive, slvOut, slvHit, slvRd;
    logic [4:0] bitCnt;
    logic [15:0] slvSh;
    wire logic mdcRise = mdcS && !mdcD;
    wire logic [12:0] hdrNow = {slvSh[11:0], mdioS};
    wire logic hdrExt = extMode && hdrNow[9];
    wire logic hdrVphy = !macMode && !extMode;
    wire logic [1:0] hdrTgt = hdrVphy ? `SMMS_TGT_VPHY : (hdrExt ? `SMMS_TGT_EXT :
        `SMMS_TGT_PHY);
    wire logic hdrOk = hdrNow[12] && (hdrNow[11:10] == `SMMS_OP_RD ||
        hdrNow[11:10] == `SMMS_OP_WR);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            preCnt <= 6'h00;
            {inFrame, slvDrive, slvOut, slvHit, slvRd, slvRdReq, slvWrReq} <= 7'h00;
            bitCnt <= 5'h00;
            slvSh <= 16'h0000;
            slvTgt <= 2'h0;
            {slvPhyAddr, slvRegAddr} <= 10'h000;
            slvWrData <= 16'h0000;
        end else begin
            slvRdReq <= 1'b0;
            slvWrReq <= 1'b0;
            if (mdcRise && !mdioMasterEn && strapDone) begin
                if (!inFrame) begin
                    if (mdioS) begin
                        preCnt <= (preCnt == `SMMS_PRE_BITS) ? preCnt : preCnt + 6'h01;
                    end else begin
                        inFrame <= (preCnt == `SMMS_PRE_BITS);
                        bitCnt <= 5'h00;
                        preCnt <= 6'h00;
                    end
                end else begin
                    bitCnt <= bitCnt + 5'h01;
                    slvSh <= {slvSh[14:0], mdioS};
                    if (bitCnt + 5'h01 == `SMMS_HDR_LAST) begin
                        inFrame <= hdrOk;
                        slvHit <= hdrOk;
                        slvRd <= (hdrNow[11:10] == `SMMS_OP_RD);
                        slvPhyAddr <= hdrNow[9:5];
                        slvRegAddr <= hdrNow[4:0];
                        slvTgt <= hdrTgt;
                        slvRdReq <= hdrOk && (hdrNow[11:10] == `SMMS_OP_RD);
                    end else if (bitCnt + 5'h01 == `SMMS_TA_FIRST && slvHit && slvRd) begin
                        slvDrive <= 1'b1;
                        slvOut <= 1'b0;
                    end else if (bitCnt + 5'h01 == `SMMS_TA_LAST && slvDrive) begin
                        slvSh <= {slvRdData[14:0], 1'b0};
                        slvOut <= slvRdData[15];
                    end else if (bitCnt + 5'h01 == `SMMS_FRAME_LAST) begin
                        inFrame <= 1'b0;
                        slvDrive <= 1'b0;
                        slvHit <= 1'b0;
                        slvWrReq <= slvHit && !slvRd;
                        slvWrData <= {slvSh[14:0], mdioS};
                    end else if (slvDrive) begin
                        slvOut <= slvSh[15];
                    end
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // phy management engine: internal forward or clause 22 master frame
    smms_pkg::smms_mm_e mmState;
    logic [63:0] mmSh;
    logic [6:0] mmCnt;
    logic [3:0] divCnt;
    logic mmWr;
    wire logic divTick = (divCnt == 4'(`SMMS_MDC_HALF_CYC - 1));
    wire logic extOk = macMode && mdioMasterEn;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mmState <= smms_pkg::MM_IDLE;
            mmSh <= 64'h0;
            mmCnt <= 7'h00;
            divCnt <= 4'h0;
            {mdcOut, mmWr, pmDone, pmErr, pmIntReq} <= 5'h00;
            pmRdData <= 16'h0000;
        end else begin
            pmDone <= 1'b0;
            pmErr <= 1'b0;
            pmIntReq <= 1'b0;
            divCnt <= divTick ? 4'h0 : divCnt + 4'h1;
            case (mmState)
                smms_pkg::MM_IDLE: begin
                    mdcOut <= 1'b0;
                    if (pmStart && pmExt && !extOk) begin
                        pmErr <= 1'b1;
                    end else if (pmStart && pmExt) begin
                        mmState <= smms_pkg::MM_FRAME;
                        mmWr <= pmWrite;
                        mmCnt <= 7'h00;
                        mmSh <= {`SMMS_PREAMBLE, 2'b01, pmWrite ? `SMMS_OP_WR : `SMMS_OP_RD,
                            pmPhyAddr, pmRegAddr, 2'b10, pmWrData};
                    end else if (pmStart) begin
                        mmState <= smms_pkg::MM_INT;
                        pmIntReq <= 1'b1;
                    end
                end
                smms_pkg::MM_FRAME: begin
                    if (divTick) begin
                        mdcOut <= !mdcOut;
                        if (mdcOut) begin
                            mmSh <= {mmSh[62:0], 1'b0};
                            mmCnt <= mmCnt + 7'h01;
                        end else if (mmCnt >= `SMMS_MM_DATA) begin
                            pmRdData <= {pmRdData[14:0], mdioS};
                        end
                        if (!mdcOut && mmCnt == `SMMS_MM_LAST) begin
                            mmState <= smms_pkg::MM_IDLE;
                            pmDone <= 1'b1;
                        end
                    end
                end
                smms_pkg::MM_INT: begin
                    if (pmIntAck) begin
                        pmRdData <= pmIntRdData;
                        pmDone <= 1'b1;
                        mmState <= smms_pkg::MM_IDLE;
                    end
                end
                default: mmState <= smms_pkg::MM_IDLE;
            endcase
        end
    end
    assign pmBusy = (mmState != smms_pkg::MM_IDLE);
    wire logic mmDrive = (mmState == smms_pkg::MM_FRAME) && (mmWr || mmCnt < `SMMS_MM_TA);
    assign mdcOe = mdioMasterEn;
    assign mdioOut = mdioMasterEn ? mmSh[63] : slvOut;
    assign mdioOe = mdioMasterEn ? mmDrive : slvDrive;
    ////////////////////////////////////////////////////////////////////////////
    // spi burst address stepping
    function automatic logic [15:0] stepAddr(input logic [15:0] a, input logic [1:0] s);
        stepAddr = (s == `SMMS_STEP_INC) ? a + 16'h0001 :
            ((s == `SMMS_STEP_DEC) ? a - 16'h0001 : a);
    endfunction
    logic [1:0] spiMode;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            spiRegAddr <= 16'h0000;
            spiMode <= `SMMS_STEP_FIX;
        end else if (spiEnable && spiBurstStart) begin
            spiRegAddr <= spiStartAddr;
            spiMode <= spiStep;
        end else if (spiEnable && spiWordDone) begin
            spiRegAddr <= stepAddr(spiRegAddr, spiMode);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // i2c slave bit level
    logic [3:0] i2cBit;
    logic [7:0] i2cSh;
    wire logic sclRise = sclS && !sclD;
    wire logic sclFall = !sclS && sclD;
    wire logic sdaFall = !sdaS && sdaD && sclS;
    wire logic sdaRise = sdaS && !sdaD && sclS;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {i2cStart, i2cStop, i2cByteValid, sdaOe} <= 4'h0;
            i2cBit <= 4'h0;
            i2cSh <= 8'h00;
            i2cByte <= 8'h00;
        end else begin
            i2cStart <= i2cEnable && sdaFall;
            i2cStop <= i2cEnable && sdaRise;
            i2cByteValid <= 1'b0;
            if (!i2cEnable || sdaFall || sdaRise) begin
                i2cBit <= 4'h0;
                sdaOe <= 1'b0;
            end else if (sclRise && i2cBit < 4'h8) begin
                i2cSh <= {i2cSh[6:0], sdaS};
                i2cBit <= i2cBit + 4'h1;
            end else if (sclFall && i2cBit == 4'h8) begin
                sdaOe <= 1'b1;
                i2cByte <= i2cSh;
                i2cByteValid <= 1'b1;
                i2cBit <= 4'h9;
            end else if (sclFall && i2cBit == 4'h9) begin
                sdaOe <= 1'b0;
                i2cBit <= 4'h0;
            end
        end
    end
    assign sdaOut = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // eeprom loader and controller port arbitration
    smms_pkg::smms_ld_e ldState;
    logic ldPend, ownCpu;
    logic [15:0] ldIdx;
    wire logic [15:0] ldLen = `SMMS_LD_BASE_WORDS << eepSize;
    assign loadBusy = ldPend || (ldState != smms_pkg::LD_IDLE);
    assign cpuEepGrant = loadDone && managed && !loadBusy;
    assign cpuEepAck = eepAck && ownCpu;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ldState <= smms_pkg::LD_IDLE;
            ldPend <= 1'b1;
            {loadDone, ownCpu, cfgWr, eepReq, eepWrite} <= 5'h00;
            ldIdx <= 16'h0000;
            {cfgAddr, eepAddr} <= 32'h0;
            {cfgData, eepWrData} <= 16'h0000;
        end else begin
            cfgWr <= 1'b0;
            if (digitalRst || reloadCmd) begin
                ldPend <= 1'b1;
            end
            case (ldState)
                smms_pkg::LD_IDLE: begin
                    if (ldPend && strapDone && !eepReq) begin
                        ldPend <= digitalRst || reloadCmd;
                        loadDone <= 1'b0;
                        ldIdx <= 16'h0000;
                        ldState <= smms_pkg::LD_REQ;
                    end else if (cpuEepGrant && cpuEepReq && !eepReq) begin
                        eepReq <= 1'b1;
                        ownCpu <= 1'b1;
                        eepWrite <= cpuEepWrite;
                        eepAddr <= cpuEepAddr;
                        eepWrData <= cpuEepWrData;
                    end else if (eepAck) begin
                        eepReq <= 1'b0;
                        ownCpu <= 1'b0;
                    end
                end
                smms_pkg::LD_REQ: begin
                    eepReq <= 1'b1;
                    eepWrite <= 1'b0;
                    eepAddr <= ldIdx;
                    ldState <= smms_pkg::LD_WAIT;
                end
                smms_pkg::LD_WAIT: begin
                    if (eepAck) begin
                        eepReq <= 1'b0;
                        cfgWr <= 1'b1;
                        cfgAddr <= ldIdx;
                        cfgData <= eepRdData;
                        ldIdx <= ldIdx + 16'h0001;
                        if (ldIdx + 16'h0001 == ldLen) begin
                            ldState <= smms_pkg::LD_IDLE;
                            loadDone <= 1'b1;
                        end else begin
                            ldState <= smms_pkg::LD_REQ;
                        end
                    end
                end
                default: ldState <= smms_pkg::LD_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_ext_refused;
        @(posedge mclk) disable iff (!resetn)
        (mmState == smms_pkg::MM_IDLE && pmStart && pmExt && !macMode) |=> pmErr && !pmBusy;
    endproperty
    a_ext_refused: assert property (p_ext_refused) else $error("ext phy in phy mode");
    logic [10:0] frmCyc;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            frmCyc <= 11'h000;
        end else begin
            frmCyc <= (mmState == smms_pkg::MM_FRAME) ? frmCyc + 11'h001 : 11'h000;
        end
    end
    property p_frame_len;
        @(posedge mclk) disable iff (!resetn)
        $fell(mmState == smms_pkg::MM_FRAME) |-> pmDone && frmCyc >= `SMMS_FRM_MIN &&
            frmCyc <= `SMMS_FRM_MAX;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("master frame length wrong");
    property p_ext_upper;
        @(posedge mclk) disable iff (!resetn)
        (slvRdReq || slvWrReq) && slvTgt == `SMMS_TGT_EXT |-> slvPhyAddr[4] && extMode;
    endproperty
    a_ext_upper: assert property (p_ext_upper) else $error("extended at low addr");
    property p_vphy_only;
        @(posedge mclk) disable iff (!resetn)
        (slvRdReq || slvWrReq) && !macMode && !extMode |-> slvTgt == `SMMS_TGT_VPHY;
    endproperty
    a_vphy_only: assert property (p_vphy_only) else $error("vphy not selected");
    property p_strap_hold;
        @(posedge mclk) disable iff (!resetn)
        strapDone |=> $stable(macMode) && $stable(mgmtMode) && $stable(eepSize);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
    property p_reload;
        @(posedge mclk) disable iff (!resetn)
        reloadCmd |=> ##[0:3] loadBusy;
    endproperty
    a_reload: assert property (p_reload) else $error("reload ignored");
    property p_cpu_after_load;
        @(posedge mclk) disable iff (!resetn)
        cpuEepGrant |-> loadDone && managed && ldState == smms_pkg::LD_IDLE;
    endproperty
    a_cpu_after_load: assert property (p_cpu_after_load) else $error("early cpu");
    property p_spi_inc;
        @(posedge mclk) disable iff (!resetn)
        spiEnable && !spiBurstStart && spiWordDone && spiMode == `SMMS_STEP_INC
        |=> spiRegAddr == $past(spiRegAddr) + 16'h0001;
    endproperty
    a_spi_inc: assert property (p_spi_inc) else $error("spi address not stepped");
    property p_master_mode;
        @(posedge mclk) disable iff (!resetn)
        mdcOut || mmState == smms_pkg::MM_FRAME |-> macMode && mgmtMode[1];
    endproperty
    a_master_mode: assert property (p_master_mode) else $error("master out of mode");
    property p_i2c_start;
        @(posedge mclk) disable iff (!resetn)
        i2cEnable && sdaFall |=> i2cStart;
    endproperty
    a_i2c_start: assert property (p_i2c_start) else $error("start missed");
    c_load: cover property (@(posedge mclk) disable iff (!resetn) $rose(loadDone));
    c_slv_ext: cover property (@(posedge mclk) disable iff (!resetn)
        slvWrReq && slvTgt == `SMMS_TGT_EXT);
    c_master: cover property (@(posedge mclk) disable iff (!resetn)
        pmDone && mdioMasterEn);
endmodule

// [test/smms_mdio_host.sv]
// Purpose: management master model driving the mdio pins
// Assumes: 300 ns link clock period (100 ns high, 200 ns low), pull-up on the data line
// Notes: link clock stands low between frames
module smms_mdio_host (
    // pins
    output logic mdc,
    output logic mdio,
    input wire logic mdioWire
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        mdc = 1'b0;
        mdio = 1'b1;
    end
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hFFFFFFFF, 2'h1, op, phy, rg, 2'h2, wd};
        for (int i = 0; i < 64; i++) begin
            mdio = (op == 2'h2 && i > 45) ? 1'b1 : bits[63 - i];
            #100 mdc = 1'b1;
            #100 mdc = 1'b0;
            #50 if (i > 46 && i < 63) rd = {rd[14:0], mdioWire};
            #50;
        end
        mdio = 1'b1;
    endtask
endmodule

// [test/smms_top_tb.sv]
// Purpose: self-checking bench of the mode select front end
// Assumes: 40 MHz mclk, eeprom and cpu modelled in the bench
// Notes: i2c pins held idle except in t_i2c
`include "smms_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module smms_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, resetn, macStrap, eepTypeStrap, mdcIn, hostMdio, pmStart, pmWrite, pmExt;
    logic pmIntAck, spiBurstStart, spiWordDone, sclIn, sdaIn, digitalRst, reloadCmd, eepAck;
    logic cpuEepReq, cpuEepWrite, macMode, eepI2cSel, spiEnable, i2cEnable, mdioMasterEn;
    logic mdcOut, mdcOe, mdioOut, mdioOe, slvRdReq, slvWrReq, pmBusy, pmDone, pmErr, pmIntReq;
    logic sdaOut, sdaOe, i2cStart, i2cStop, i2cByteValid, loadBusy, loadDone, cfgWr, eepReq;
    logic eepWrite, cpuEepGrant, cpuEepAck, mdcPrev;
    logic [63:0] mFrm;
    logic [1:0] mngtStrap, eepSizeStrap, mgmtMode, eepSize, slvTgt, spiStep, capTgt;
    logic [4:0] pmPhyAddr, pmRegAddr, slvPhyAddr, slvRegAddr, capPhy;
    logic [7:0] i2cByte, cfgData, eepWrData, eepRdData, cpuEepWrData;
    logic [15:0] slvWrData, slvRdData, pmWrData, pmRdData, pmIntRdData, spiStartAddr;
    logic [15:0] spiRegAddr, cfgAddr, eepAddr, cpuEepAddr, capWd, rd;
    int error_cnt = 0, check_count = 0, nCfg = 0;
    wire logic mdioIn;
    assign mdioIn = mdioOe ? mdioOut : hostMdio;
    smms_top DUT (.*);
    smms_mdio_host HOST (.mdc(mdcIn), .mdio(hostMdio), .mdioWire(mdioIn));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        eepAck <= eepReq && !eepAck;
        mdcPrev <= mdcOut;
        if (mdcOut && !mdcPrev) mFrm <= {mFrm[62:0], mdioOut};
        eepRdData <= eepAddr[7:0] ^ 8'h5A;
        if (cfgWr) begin
            `CHK(cfgData, nCfg[7:0] ^ 8'h5A)
            nCfg++;
        end
        if (slvWrReq || slvRdReq) begin
            capTgt <= slvTgt;
            capPhy <= slvPhyAddr;
            capWd <= slvWrData;
        end
    end
    task automatic end_sim;
        if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic waitLv(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        check_count++;
        while (s !== v && n < lim) begin
            @(negedge mclk);
            n++;
        end
        if (s !== v) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, s, v);
            end_sim();
        end
    endtask
    task automatic loadChk;
        repeat (2) @(negedge mclk);
        waitLv(loadBusy, 1'b0, 3000);
        @(negedge mclk);
        `CHK(nCfg, 16 << eepSizeStrap)
        `CHK(loadDone, 1'b1)
    endtask
    task automatic rst(input logic mac, input logic [1:0] mg);
        @(posedge mclk);
        macStrap <= mac;
        mngtStrap <= mg;
        resetn <= 1'b0;
        nCfg = 0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        loadChk();
    endtask
    task automatic t_straps;
        `CHK(macMode, 1'b0)
        `CHK(mgmtMode, `SMMS_MG_EXT)
        `CHK(mdioMasterEn, 1'b0)
        `CHK({eepI2cSel, eepSize}, {eepTypeStrap, eepSizeStrap})
        @(posedge mclk);
        macStrap <= 1'b0;
        mngtStrap <= `SMMS_MG_SPI;
        repeat (8) @(negedge mclk);
        `CHK({macMode, mgmtMode}, 3'h1)
    endtask
    task automatic t_reload;
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            nCfg = 0;
            reloadCmd <= (k == 0);
            digitalRst <= (k == 1);
            @(posedge mclk);
            {reloadCmd, digitalRst} <= 2'h0;
            loadChk();
        end
    endtask
    task automatic t_slave;
        HOST.frame(`SMMS_OP_WR, 5'h11, 5'h05, 16'hA55A, rd);
        repeat (8) @(negedge mclk);
        `CHK({capTgt, capPhy, capWd}, {`SMMS_TGT_EXT, 5'h11, 16'hA55A})
        HOST.frame(`SMMS_OP_RD, 5'h03, 5'h02, 16'h0000, rd);
        `CHK({capTgt, capPhy}, {`SMMS_TGT_PHY, 5'h03})
        `CHK(rd, slvRdData)
    endtask
    task automatic t_pm;
        @(posedge mclk);
        {pmStart, pmExt} <= 2'h3;
        @(posedge mclk);
        {pmStart, pmExt} <= 2'h0;
        waitLv(pmErr, 1'b1, 4);
        @(posedge mclk);
        pmStart <= 1'b1;
        @(posedge mclk);
        pmStart <= 1'b0;
        waitLv(pmIntReq, 1'b1, 4);
        @(posedge mclk);
        pmIntAck <= 1'b1;
        pmIntRdData <= 16'h3C96;
        @(posedge mclk);
        pmIntAck <= 1'b0;
        waitLv(pmDone, 1'b1, 4);
        `CHK(pmRdData, 16'h3C96)
    endtask
    task automatic t_cpu;
        `CHK(cpuEepGrant, 1'b1)
        @(posedge mclk);
        {cpuEepReq, cpuEepWrite, cpuEepAddr, cpuEepWrData} <= {2'h3, 16'h0123, 8'h6E};
        waitLv(eepReq, 1'b1, 4);
        `CHK({eepWrite, eepAddr, eepWrData}, {1'b1, 16'h0123, 8'h6E})
        waitLv(cpuEepAck, 1'b1, 4);
        @(posedge mclk);
        cpuEepReq <= 1'b0;
    endtask
    task automatic t_i2c;
        logic [9:0] pat = 10'h29A;
        `CHK({spiEnable, i2cEnable, mdioMasterEn}, 3'h2)
        HOST.frame(`SMMS_OP_WR, 5'h14, 5'h01, 16'h0F0F, rd);
        repeat (8) @(negedge mclk);
        `CHK({capTgt, capPhy}, {`SMMS_TGT_VPHY, 5'h14})
        @(posedge mclk);
        sdaIn <= 1'b0;
        waitLv(i2cStart, 1'b1, 6);
        for (int i = 0; i < 10; i++) begin
            repeat (4) @(posedge mclk);
            sclIn <= 1'b0;
            repeat (4) @(posedge mclk);
            sdaIn <= pat[9 - i];
            repeat (4) @(posedge mclk);
            sclIn <= 1'b1;
            if (i == 8) `CHK({sdaOe, i2cByte}, 9'h1A6)
        end
        repeat (4) @(posedge mclk);
        sdaIn <= 1'b1;
        waitLv(i2cStop, 1'b1, 6);
        `CHK(sdaOe, 1'b0)
    endtask
    task automatic t_spi;
        `CHK({spiEnable, i2cEnable, mdioMasterEn, mdcOe}, 4'hB)
        for (int s = 0; s < 3; s++) begin
            @(posedge mclk);
            {spiBurstStart, spiStep, spiStartAddr} <= {1'b1, 2'(s), 16'h0100};
            for (int w = 0; w < 2; w++) begin
                @(posedge mclk);
                {spiBurstStart, spiWordDone} <= 2'h1;
                @(posedge mclk);
                spiWordDone <= 1'b0;
            end
            repeat (2) @(negedge mclk);
            `CHK(spiRegAddr, s == 1 ? 16'h0102 : s == 2 ? 16'h00FE : 16'h0100)
        end
        @(posedge mclk);
        {pmStart, pmExt, pmWrite} <= 3'h7;
        {pmPhyAddr, pmRegAddr, pmWrData} <= {5'h09, 5'h04, 16'hBEEF};
        @(posedge mclk);
        pmStart <= 1'b0;
        waitLv(pmDone, 1'b1, 1500);
        `CHK(pmErr, 1'b0)
        repeat (2) @(negedge mclk);
        `CHK(mFrm, {32'hFFFFFFFF, 4'h5, 5'h09, 5'h04, 2'h2, 16'hBEEF})
    endtask
    initial begin
        {resetn, pmStart, pmWrite, pmExt, pmIntAck, spiBurstStart, spiWordDone} = '0;
        {digitalRst, reloadCmd, cpuEepReq, cpuEepWrite, spiStep, pmIntRdData} = '0;
        {pmPhyAddr, pmRegAddr, pmWrData, spiStartAddr, cpuEepAddr, cpuEepWrData} = '0;
        {macStrap, mngtStrap, eepTypeStrap, eepSizeStrap, sclIn, sdaIn} = 8'hBF;
        slvRdData = 16'hC3A5;
        rst(1'b1, `SMMS_MG_EXT);
        t_straps();
        t_reload();
        t_slave();
        t_pm();
        t_cpu();
        rst(1'b1, `SMMS_MG_I2C);
        t_i2c();
        rst(1'b0, `SMMS_MG_SPI);
        t_spi();
        end_sim();
    end
endmodule
